//--- logic/utrc_core.sv
// Serial transmitter and receiver core with APB registers
// Summary of operation
// (RULE1) Bit rate is programmable; the 2 Mbps ceiling is the fastest supported. At a 10 MHz clock the core reaches 1.25 Mbps at most (8 ticks a bit).
// (RULE2) Five to eight data bits per frame, same setting both ways.
// (RULE3) Parity even, odd, stick or none, generated and checked.
// (RULE4) Transmitter sends one or two stop bits.
// (RULE5) Received pause and resume characters stop and restart transmission.
// (RULE6) Break is forced on the line and detected on receive.
// (RULE7) Transmit buffer 64 by 8, receive buffer 64 by 12.
// (RULE8) Entry holds data 7:0, framing 8, parity 9, break 10.
// (RULE9) Character arriving at full receive buffer is dropped and overrun raised.
// (RULE10) Pending overrun is stored in bit 11 of next stored character.
// (RULE11) Enabled, buffered data is sent back to back until empty.
// (RULE12) Busy is set while transmit buffer holds data, even when disabled.
// (RULE13) Busy clears once buffer empty and last stop bit sent.
// (RULE14) Each bit is the majority of three samples around mid bit.
// (RULE15) Start is rechecked on the eighth tick (fourth at 8 ticks a bit); high means false start.
// (RULE16) Data bits sampled every bit period after a valid start.
// (RULE17) Parity checked, then a low stop bit is a framing error.
// (RULE18) Completed characters are stored with their error bits.
// (RULE19) Buffering off makes each direction a one-entry holding register.
// (RULE20) Unbuffered, a new character before the old one is read overruns.
// (RULE21) Oversampling tick pulses at 16 or 8 times the bit rate.
// (RULE22) Divisor is 16-bit integer plus 6-bit fraction.
// (RULE23) Ready-to-receive is asserted until receive level reaches watermark.
// (RULE24) With permit flow on, transmit starts only while permit is asserted.
// (RULE25) Line idles high; start low, data LSB first, parity, stop.
// (RULE26) Overrun, framing, parity and break stay visible to software.
`timescale 1ns/1ps
module utrc_core import utrc_pkg::*; (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Hardware flow control, active low
  input wire logic tx_permit_n,
  output logic rx_ready_n
);
  logic [6:0] tx_line_control;
  logic [5:0] ctrl;
  logic [21:0] divisor;
  logic [15:0] xchar;
  logic [6:0] wmark;
  logic [3:0] err;
  logic tx_paused;

  // APB decode
  wire setup = psel && !penable;
  wire commit = psel && penable && pready;
  wire wr = commit && pwrite;
  wire rd = commit && !pwrite;
  wire hit_data = (paddr == OFS_DATA);
  wire hit_flag = (paddr == OFS_FLAG);
  wire hit_err = (paddr == OFS_ERR);
  wire hit_line = (paddr == OFS_LINE);
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_div = (paddr == OFS_DIV);
  wire hit_xchar = (paddr == OFS_XCHAR);
  wire hit_wmark = (paddr == OFS_WMARK);
  wire mapped = hit_data || hit_flag || hit_err || hit_line || hit_ctrl
    || hit_div || hit_xchar || hit_wmark;

  wire en = ctrl[CT_EN];
  wire ovs = ctrl[CT_OVS];
  wire [3:0] last_sub = ovs ? LAST8 : LAST16;
  wire [3:0] half = ovs ? HALF8 : HALF16;
  wire [3:0] nbits_m1 = {2'b01, tx_line_control[LN_WLEN+1:LN_WLEN]};
  wire [7:0] dmask = 8'hff >> (3'd3 - tx_line_control[LN_WLEN+1:LN_WLEN]);
  wire pen = tx_line_control[LN_PEN];
  wire even = tx_line_control[LN_EVEN];
  wire stick = tx_line_control[LN_STICK];
  wire brk = tx_line_control[LN_BRK];

  // Fractional divider making the oversampling tick
  logic [15:0] bcnt;
  logic [5:0] facc;
  logic tick;
  wire [15:0] dint = divisor[21:DIV_FRAC_W];
  wire [6:0] fsum = {1'b0, facc} + {1'b0, divisor[DIV_FRAC_W-1:0]};
  wire [15:0] dint_m1 = (dint == 16'h0000) ? 16'h0000 : dint - 16'h0001;
  wire [15:0] next_bcnt = dint_m1 + {15'h0000, fsum[6]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bcnt <= 16'h0000;
      facc <= 6'h00;
      tick <= 1'b0;
    end
    else if (bcnt == 16'h0000)
    begin
      bcnt <= next_bcnt; // RULE22
      facc <= fsum[5:0];
      tick <= 1'b1; // RULE21 RULE1
    end
    else
    begin
      bcnt <= bcnt - 16'h0001;
      tick <= 1'b0;
    end
  end

  // Buffers
  logic [7:0] tx_rdata;
  logic [11:0] rx_rdata;
  logic [6:0] tx_count;
  logic [6:0] rx_count;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic tx_pop;
  logic rx_push;
  logic [11:0] rx_word;
  wire tx_push = wr && hit_data;
  wire rx_pop = rd && hit_data;

  utrc_fifo #(.W(TX_W)) u_txf ( // RULE7 RULE19
    .pclk(pclk), .presetn(presetn), .single(!ctrl[CT_FIFO]),
    .push(tx_push), .wdata(pwdata[7:0]), .pop(tx_pop), .rdata(tx_rdata),
    .count(tx_count), .full(tx_full), .empty(tx_empty)
  );

  utrc_fifo #(.W(RX_W)) u_rxf ( // RULE7 RULE19
    .pclk(pclk), .presetn(presetn), .single(!ctrl[CT_FIFO]),
    .push(rx_push), .wdata(rx_word), .pop(rx_pop), .rdata(rx_rdata),
    .count(rx_count), .full(rx_full), .empty(rx_empty)
  );

  // Transmitter
  utrc_state_e tx_st;
  logic [3:0] tx_sub;
  logic [3:0] tx_cnt;
  logic [7:0] tx_sh;
  logic tx_par;
  wire tx_end = tick && (tx_sub == last_sub);
  wire permit = !ctrl[CT_CTS] || !tx_permit_n;
  wire [7:0] tx_data = tx_rdata & dmask;
  wire tx_go = (tx_st == ST_IDLE) && !tx_empty && en && !tx_paused && permit; // RULE11 RULE5 RULE24
  wire busy = !tx_empty || (tx_st != ST_IDLE); // RULE12 RULE13
  wire par_calc = stick ? !even : (even ? ^tx_data : ~^tx_data); // RULE3
  assign tx_pop = tx_go;
  wire tx_line = (tx_st == ST_START) ? 1'b0 : // RULE25
    (tx_st == ST_DATA) ? tx_sh[0] :
    (tx_st == ST_PAR) ? tx_par : 1'b1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st <= ST_IDLE;
      tx_sub <= 4'h0;
      tx_cnt <= 4'h0;
      tx_sh <= 8'h00;
      tx_par <= 1'b0;
      txd <= 1'b1;
    end
    else
    begin
      txd <= tx_line && !brk; // RULE6
      if (tick)
        tx_sub <= (tx_sub == last_sub) ? 4'h0 : tx_sub + 4'h1;
      unique case (tx_st)
        ST_IDLE:
          if (tx_go)
          begin
            tx_sh <= tx_data;
            tx_par <= par_calc;
            tx_sub <= 4'h0;
            tx_st <= ST_START;
          end
        ST_START:
          if (tx_end)
          begin
            tx_cnt <= 4'h0;
            tx_st <= ST_DATA;
          end
        ST_DATA:
          if (tx_end)
          begin
            tx_sh <= tx_sh >> 1;
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == nbits_m1) // RULE2
            begin
              tx_cnt <= 4'h0;
              tx_st <= pen ? ST_PAR : ST_STOP;
            end
          end
        ST_PAR:
          if (tx_end)
            tx_st <= ST_STOP;
        ST_STOP:
          if (tx_end)
          begin
            if (tx_line_control[LN_STOP2] && tx_cnt == 4'h0)
              tx_cnt <= 4'h1; // RULE4
            else
              tx_st <= ST_IDLE; // RULE11
          end
      endcase
    end
  end

  // Receiver
  utrc_state_e rx_st;
  logic [3:0] rx_sub;
  logic [3:0] rx_cnt;
  logic [7:0] rx_sh;
  logic [1:0] hist;
  logic rx_prev;
  logic rx_pbit;
  logic rx_pe;
  logic ovr_pend;
  wire maj = (hist[1] & hist[0]) | (hist[1] & rxd) | (hist[0] & rxd); // RULE14
  wire at_mid = tick && (rx_sub == half);
  wire at_chk = tick && (rx_sub == half - 4'h1);
  wire rx_done = (rx_st == ST_STOP) && at_mid;
  wire rx_fe = !maj;
  wire rx_be = (rx_sh == 8'h00) && !rx_pbit && !maj;
  wire exp_par = stick ? !even : (even ? ^rx_sh : ~^rx_sh);
  assign rx_word = {ovr_pend, rx_be, rx_pe, rx_fe, rx_sh}; // RULE8 RULE10
  assign rx_push = rx_done && !rx_full; // RULE18

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st <= ST_IDLE;
      rx_sub <= 4'h0;
      rx_cnt <= 4'h0;
      rx_sh <= 8'h00;
      hist <= 2'b11;
      rx_prev <= 1'b1;
      rx_pbit <= 1'b0;
      rx_pe <= 1'b0;
      ovr_pend <= 1'b0;
    end
    else
    begin
      rx_prev <= rxd;
      if (tick)
      begin
        hist <= {hist[0], rxd};
        rx_sub <= (rx_sub == last_sub) ? 4'h0 : rx_sub + 4'h1;
      end
      if (rx_done)
        ovr_pend <= rx_full; // RULE9 RULE20 RULE10
      unique case (rx_st)
        ST_IDLE:
          if (en && rx_prev && !rxd)
          begin
            rx_sub <= 4'h0;
            rx_cnt <= 4'h0;
            rx_sh <= 8'h00;
            rx_pbit <= 1'b0;
            rx_pe <= 1'b0;
            rx_st <= ST_START;
          end
        ST_START:
          if (at_chk && rxd)
            rx_st <= ST_IDLE; // RULE15
          else if (at_mid)
            rx_st <= ST_DATA;
        ST_DATA:
          if (at_mid)
          begin
            rx_sh[rx_cnt[2:0]] <= maj; // RULE16 RULE25
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == nbits_m1) // RULE2
              rx_st <= pen ? ST_PAR : ST_STOP;
          end
        ST_PAR:
          if (at_mid)
          begin
            rx_pbit <= maj;
            rx_pe <= (maj != exp_par); // RULE17 RULE3
            rx_st <= ST_STOP;
          end
        ST_STOP:
          if (at_mid)
            rx_st <= ST_IDLE; // RULE17
      endcase
    end
  end

  // Pause and resume characters taken from the receive path
  wire is_pause = rx_done && (rx_sh == xchar[15:8]);
  wire is_resume = rx_done && (rx_sh == xchar[7:0]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_paused <= 1'b0;
    else if (!ctrl[CT_SWF])
      tx_paused <= 1'b0;
    else if (is_pause)
      tx_paused <= 1'b1; // RULE5
    else if (is_resume)
      tx_paused <= 1'b0; // RULE5
  end

  // Sticky errors, write one to clear; a new event beats the clear
  wire [3:0] err_set = {rx_done && rx_full, rx_done && rx_be,
    rx_done && rx_pe, rx_done && rx_fe};
  wire [3:0] err_clr = (wr && hit_err) ? pwdata[3:0] : 4'h0;

  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_line_control <= LINE_RST;
      ctrl <= CTRL_RST;
      divisor <= DIV_RST;
      xchar <= XCHAR_RST;
      wmark <= WMARK_RST;
      err <= 4'h0;
    end
    else
    begin
      err <= (err & ~err_clr) | err_set; // RULE26
      if (wr && hit_line)
        tx_line_control <= pwdata[6:0];
      if (wr && hit_ctrl)
        ctrl <= pwdata[5:0];
      if (wr && hit_div)
        divisor <= pwdata[21:0];
      if (wr && hit_xchar)
        xchar <= pwdata[15:0];
      if (wr && hit_wmark)
        wmark <= pwdata[6:0];
    end
  end

  wire [6:0] flags = {!tx_permit_n, tx_paused, tx_empty, rx_full, tx_full, rx_empty, busy};
  wire [31:0] rdata = hit_data ? {20'h00000, rx_rdata} :
    hit_flag ? {25'h0000000, flags} :
    hit_err ? {28'h0000000, err} :
    hit_line ? {25'h0000000, tx_line_control} :
    hit_ctrl ? {26'h0000000, ctrl} :
    hit_div ? {10'h000, divisor} :
    hit_xchar ? {16'h0000, xchar} :
    hit_wmark ? {25'h0000000, wmark} : 32'h00000000;

  // One access cycle: answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      rx_ready_n <= 1'b1;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite)
        prdata <= rdata;
      rx_ready_n <= ctrl[CT_RTS] && (rx_count >= wmark); // RULE23
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_with_data: assert property ((tx_push && !tx_full) |=> busy) // RULE12
    else $error("busy low with transmit data");
  a_busy_clear: assert property ($fell(busy) |-> $past(tx_st) == ST_STOP) // RULE13
    else $error("busy cleared outside stop bit");
  a_false_start: assert property ((rx_st == ST_START && at_chk && rxd) |=> rx_st == ST_IDLE) // RULE15
    else $error("false start not discarded");
  a_overrun_drop: assert property ((rx_done && rx_full) |=> ovr_pend && err[ER_OE]) // RULE9
    else $error("overrun not raised");
  a_overrun_store: assert property ((rx_push && ovr_pend) |-> rx_word[11] ##1 !ovr_pend) // RULE10
    else $error("overrun not stored then cleared");
  a_break_line: assert property (brk |=> !txd) // RULE6
    else $error("break not driven");
  a_ready_mark: assert property ((ctrl[CT_RTS] && rx_count >= wmark) |=> rx_ready_n) // RULE23
    else $error("ready not withdrawn at watermark");
  a_permit_hold: assert property ((tx_st == ST_IDLE && ctrl[CT_CTS] && tx_permit_n)
    |=> tx_st == ST_IDLE) // RULE24
    else $error("frame started without permit");
  a_start_low: assert property ((tx_st == ST_START) |=> !txd || $past(tx_st, 1) != ST_START) // RULE25
    else $error("start bit not low");
  a_stop_bits: assert property ((tx_st == ST_STOP && tx_end && !tx_line_control[LN_STOP2])
    |=> tx_st == ST_IDLE) // RULE4
    else $error("extra stop bit");

  c_frame_sent: cover property (tx_st == ST_STOP ##1 tx_st == ST_IDLE);
  c_char_stored: cover property (rx_push);
  c_overrun: cover property (rx_done && rx_full);
  c_false_start: cover property (rx_st == ST_START && at_chk && rxd);
endmodule

//--- logic/utrc_pkg.sv
// Shared constants and types of the serial transmitter and receiver core
package utrc_pkg;
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam int TX_W = 8;
  localparam int RX_W = 12;
  localparam int CLK_HZ = 10_000_000;
  localparam int MAX_BPS = 2_000_000;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_FLAG = 8'h04;
  localparam logic [7:0] OFS_ERR = 8'h08;
  localparam logic [7:0] OFS_LINE = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_DIV = 8'h14;
  localparam logic [7:0] OFS_XCHAR = 8'h18;
  localparam logic [7:0] OFS_WMARK = 8'h1c;
  // tx_line_control fields
  localparam int LN_WLEN = 0;
  localparam int LN_PEN = 2;
  localparam int LN_EVEN = 3;
  localparam int LN_STICK = 4;
  localparam int LN_STOP2 = 5;
  localparam int LN_BRK = 6;
  // Control fields
  localparam int CT_EN = 0;
  localparam int CT_FIFO = 1;
  localparam int CT_OVS = 2;
  localparam int CT_RTS = 3;
  localparam int CT_CTS = 4;
  localparam int CT_SWF = 5;
  // flag_register fields
  localparam int FL_BUSY = 0;
  localparam int FL_RXE = 1;
  localparam int FL_TXF = 2;
  localparam int FL_RXF = 3;
  localparam int FL_TXE = 4;
  localparam int FL_PAUSE = 5;
  // Error register and receive entry fields
  localparam int ER_FE = 0;
  localparam int ER_PE = 1;
  localparam int ER_BE = 2;
  localparam int ER_OE = 3;
  localparam int DIV_FRAC_W = 6;
  localparam logic [6:0] LINE_RST = 7'h03;
  localparam logic [5:0] CTRL_RST = 6'h02;
  localparam logic [21:0] DIV_RST = 22'h000040;
  localparam logic [15:0] XCHAR_RST = 16'h1311;
  localparam logic [6:0] WMARK_RST = 7'h20;
  // Oversampling: 16 or 8 ticks a bit
  localparam logic [3:0] LAST16 = 4'hf;
  localparam logic [3:0] LAST8 = 4'h7;
  localparam logic [3:0] HALF16 = 4'h8;
  localparam logic [3:0] HALF8 = 4'h4;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_PAR = 5'b01000,
    ST_STOP = 5'b10000
  } utrc_state_e;
endpackage

//--- logic/utrc_fifo.sv
// Flip-flop FIFO with optional one-entry holding mode
`timescale 1ns/1ps
module utrc_fifo import utrc_pkg::*; #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Mode
  input wire logic single,
  // Fill side
  input wire logic push,
  input wire logic [W-1:0] wdata,
  // Drain side
  input wire logic pop,
  output logic [W-1:0] rdata,
  // Level
  output logic [CNT_W-1:0] count,
  output logic full,
  output logic empty
);
  logic [W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  // Flags limited to one entry give the holding-register view
  assign full = single ? (count != 7'h00) : (count == 7'h40);
  assign empty = (count == 7'h00);
  assign rdata = mem[rptr];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr <= 6'h00;
      rptr <= 6'h00;
      count <= 7'h00;
    end
    else
    begin
      wptr <= wptr + {5'h00, do_push};
      rptr <= rptr + {5'h00, do_pop};
      count <= count + {6'h00, do_push} - {6'h00, do_pop};
    end
  end

  always_ff @(posedge pclk)
  begin
    if (do_push)
      mem[wptr] <= wdata;
  end
endmodule

//--- verification/utrc_remote.sv
// Remote serial device model facing the core's line pins
`timescale 1ns/1ps
module utrc_remote #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic pclk,
  // Serial line
  input wire logic txd,
  output logic rxd,
  // Flow control, active low
  output logic tx_permit_n
);
  // Line idles high as through a pull-up
  initial
  begin
    rxd = 1'b1;
    tx_permit_n = 1'b0;
  end
  // Frame bit 0 is the start bit; callers enter right after an edge
  task automatic send(input logic [11:0] fr, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd <= fr[i];
      repeat (BIT) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  task automatic glitch(input int len);
    rxd <= 1'b0;
    repeat (len) @(posedge pclk);
    rxd <= 1'b1;
  endtask
  task automatic permit(input logic lvl);
    tx_permit_n <= lvl;
  endtask
  // Returns at mid last stop bit so a following start is not missed
  task automatic catch(input int n, output logic [11:0] fr, output logic ok);
    int w;
    fr = 12'hfff;
    ok = 1'b0;
    w = 0;
    while (txd !== 1'b0)
    begin
      @(posedge pclk);
      w++;
      if (w > 4000)
        return;
    end
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      if (i > 0)
        repeat (BIT) @(posedge pclk);
      fr[i] = txd;
    end
    ok = 1'b1;
  endtask
endmodule

//--- verification/tb_uart_tx_rx_core.sv
// Self-checking bench of the serial core against a remote line model
`timescale 1ns/1ps
module tb_uart_tx_rx_core import utrc_pkg::*; ;
  localparam int BIT = 16;
  typedef struct {logic [6:0] ln; logic [7:0] d; logic [11:0] rx;} utrc_row_s;
  utrc_row_s rows [6] = '{'{7'h00, 8'h15, 12'h015}, '{7'h05, 8'h2a, 12'h02a},
    '{7'h0e, 8'h5b, 12'h05b}, '{7'h17, 8'ha5, 12'h0a5}, '{7'h1f, 8'h3c, 12'h03c},
    '{7'h23, 8'hff, 12'h0ff}};
  logic [7:0] ra [7] = '{OFS_LINE, OFS_CTRL, OFS_DIV, OFS_XCHAR, OFS_WMARK, OFS_ERR, OFS_FLAG};
  logic [31:0] rv [7] = '{32'h03, 32'h02, 32'h40, 32'h1311, 32'h20, 32'h0, 32'h52};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, tx_permit_n, ok;
  logic rx_ready_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] f, x;
  int error_cnt = 0;
  int num_checks = 0;
  int k, m;

  utrc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_permit_n(tx_permit_n),
    .rx_ready_n(rx_ready_n));
  utrc_remote #(.BIT(BIT)) i_remote (.pclk(pclk), .txd(txd), .rxd(rxd),
    .tx_permit_n(tx_permit_n));

  always #50 pclk = ~pclk;

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One setup, access until pready, then an idle edge before the next request
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      error_cnt++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  function automatic logic [11:0] frame_of(input logic [6:0] ln, input logic [7:0] d,
                                           output int n);
    int nb;
    logic [7:0] v;
    frame_of = 12'hfff;
    frame_of[0] = 1'b0;
    nb = 5 + int'(ln[1:0]);
    v = d & (8'hff >> (8 - nb));
    for (int i = 0; i < nb; i++)
      frame_of[i + 1] = v[i];
    n = nb + 1;
    if (ln[LN_PEN])
    begin
      frame_of[n] = ln[LN_STICK] ? ~ln[LN_EVEN] : (ln[LN_EVEN] ? ^v : ~^v);
      n++;
    end
    n = n + 1 + int'(ln[LN_STOP2]);
  endfunction
  task automatic tx_expect(input logic [6:0] ln, input logic [7:0] d);
    logic [11:0] e;
    int n;
    e = frame_of(ln, d, n);
    i_remote.catch(n, f, ok);
    if (!ok)
    begin
      error_cnt++;
      tally_and_finish();
    end
    chk({20'h0, f}, {20'h0, e});
  endtask
  task automatic rx_send(input logic [6:0] ln, input logic [7:0] d);
    logic [11:0] e;
    int n;
    e = frame_of(ln, d, n);
    i_remote.send(e, n);
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i])
    begin
      rd(ra[i], q);
      chk(q, rv[i]);
    end
    apb(1'b0, 8'h40, 32'h0, q, ok);
    chk({q[31:1], ok}, 32'h1);
    // Disabled: data waits, busy already up
    wr(OFS_DATA, 32'h81);
    wr(OFS_DATA, 32'h7e);
    rd(OFS_FLAG, q);
    chk(q, 32'h43);
    chk({31'h0, txd}, 32'h1);
    wr(OFS_CTRL, 32'h03);
    tx_expect(7'h03, 8'h81);
    tx_expect(7'h03, 8'h7e);
    foreach (rows[i])
    begin
      wr(OFS_LINE, {25'h0, rows[i].ln});
      wr(OFS_DATA, {24'h0, rows[i].d});
      fork
        tx_expect(rows[i].ln, rows[i].d);
        begin
          rd(OFS_FLAG, q);
          chk(q & 32'h1, 32'h1);
        end
      join
      rd(OFS_FLAG, q);
      chk(q & 32'h1, 32'h1);
      k = 0;
      while (q[FL_BUSY] !== 1'b0 && k < 40)
      begin
        rd(OFS_FLAG, q);
        k++;
      end
      chk(q & 32'h1, 32'h0);
      rx_send(rows[i].ln, rows[i].d);
      rd(OFS_DATA, q);
      chk(q, {20'h0, rows[i].rx});
    end
    // Line errors with 8 bits, even parity
    wr(OFS_LINE, 32'h0f);
    x = frame_of(7'h0f, 8'h33, m);
    x[9] = ~x[9];
    i_remote.send(x, m);
    rd(OFS_DATA, q);
    chk(q, 32'h233);
    x = frame_of(7'h0f, 8'h33, m);
    x[10] = 1'b0;
    i_remote.send(x, m);
    rd(OFS_DATA, q);
    chk(q, 32'h133);
    i_remote.send(12'h000, 11);
    rd(OFS_DATA, q);
    chk(q & 32'h4ff, 32'h400);
    rd(OFS_ERR, q);
    chk(q & 32'h7, 32'h7);
    wr(OFS_ERR, 32'hf);
    rd(OFS_ERR, q);
    chk(q, 32'h0);
    i_remote.glitch(4);
    repeat (40) @(posedge pclk);
    rd(OFS_FLAG, q);
    chk(q, 32'h52);
    // Permit withheld: line must stay idle
    wr(OFS_LINE, 32'h03);
    i_remote.permit(1'b1);
    wr(OFS_CTRL, 32'h13);
    wr(OFS_DATA, 32'h5a);
    k = 0;
    repeat (100)
    begin
      @(posedge pclk);
      if (txd !== 1'b1)
        k++;
    end
    chk(k, 0);
    i_remote.permit(1'b0);
    tx_expect(7'h03, 8'h5a);
    // Break forced while idle
    wr(OFS_LINE, 32'h43);
    @(posedge pclk);
    chk({31'h0, txd}, 32'h0);
    wr(OFS_LINE, 32'h03);
    // Eight ticks a bit at divisor two keeps the bit at sixteen clocks
    wr(OFS_DIV, 32'h80);
    wr(OFS_CTRL, 32'h07);
    wr(OFS_DATA, 32'hc6);
    tx_expect(7'h03, 8'hc6);
    rx_send(7'h03, 8'h9d);
    rd(OFS_DATA, q);
    chk(q, 32'h09d);
    wr(OFS_DIV, 32'h40);
    // Pause holds queued data until resume; both characters are stored
    wr(OFS_CTRL, 32'h23);
    rx_send(7'h03, 8'h13);
    wr(OFS_DATA, 32'h4b);
    rd(OFS_FLAG, q);
    chk(q & 32'h21, 32'h21);
    fork
      rx_send(7'h03, 8'h11);
      tx_expect(7'h03, 8'h4b);
    join
    rd(OFS_DATA, q);
    chk(q, 32'h013);
    rd(OFS_DATA, q);
    chk(q, 32'h011);
    // Single holding register: second character overruns
    wr(OFS_CTRL, 32'h01);
    rx_send(7'h03, 8'ha1);
    rx_send(7'h03, 8'hb2);
    rd(OFS_DATA, q);
    chk(q, 32'h0a1);
    rd(OFS_ERR, q);
    chk(q, 32'h8);
    rx_send(7'h03, 8'hc3);
    rd(OFS_DATA, q);
    chk(q, 32'h8c3);
    // Ready withdrawn once the level reaches the watermark
    wr(OFS_WMARK, 32'h1);
    wr(OFS_CTRL, 32'h09);
    chk({31'h0, rx_ready_n}, 32'h0);
    rx_send(7'h03, 8'h6e);
    chk({31'h0, rx_ready_n}, 32'h1);
    rd(OFS_DATA, q);
    chk(q, 32'h06e);
    @(posedge pclk);
    chk({31'h0, rx_ready_n}, 32'h0);
    // Reset in mid run: line idle, bus quiet, watermark register back to its default
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({29'h0, txd, pready, rx_ready_n}, 32'h5);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_WMARK, q);
    chk(q, 32'h20);
    tally_and_finish();
  end
endmodule
